// ### hw/sacp_host.sv
`timescale 1ns/100ps
// ****************************************
// Host end: strobe, serial clock, capture
// ****************************************
module sacp_host #(
  parameter int SCK_HALF = sacp_pkg::SCK_HALF_DEF,
  parameter int DEPTH    = 32
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  sacp_link_if.host        link,
  input  wire logic        run_i,
  input  wire logic        nap_req_i,
  input  wire logic        sleep_req_i,
  output logic      [12:0] word_o,
  output logic             word_valid_o,
  input  wire logic        word_ready_i,
  output logic             busy_o
);
  localparam logic [7:0] HALF_M1 = 8'(SCK_HALF - 1);
  localparam logic [7:0] WAIT_M1 =
    8'(((sacp_pkg::ACQ_CYC > sacp_pkg::GAP_CYC) ? sacp_pkg::ACQ_CYC : sacp_pkg::GAP_CYC) - 1);
  localparam logic [7:0] THRU = 8'(sacp_pkg::THRU_CYC);

  sacp_pkg::sacp_host_st_t state_reg;  // Sequencer state
  logic [7:0]  tmr_reg;                // Phase timer
  logic [7:0]  per_reg;                // Cycles since last conversion strobe
  logic [3:0]  edge_reg;               // Serial edges issued
  logic [2:0]  pls_reg;                // Power pulses left
  logic [2:0]  pend_reg;               // Pending power pulses
  logic [12:0] rx_reg;                 // Capture shifter
  logic        push_reg;               // Word complete
  logic        sck_reg;
  logic        convert_strobe_reg;
  logic [1:0]  sdo_sync_reg;           // Data line synchroniser
  logic        fifo_ready;
  logic        take_pwr;

  assign link.sck            = sck_reg;
  assign link.convert_strobe = convert_strobe_reg;
  assign busy_o              = (state_reg != sacp_pkg::H_IDLE);
  assign take_pwr = ce_i && (state_reg == sacp_pkg::H_IDLE) && (pend_reg != 3'h0);

  // ****************************************
  // Data line synchroniser
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_sync_reg <= 2'b00;
    end else if (ce_i) begin
      sdo_sync_reg <= {sdo_sync_reg[0], link.sdo_line};
    end
  end

  // Pending power request; a new request wins over taking
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_reg <= 3'h0;
    end else if (ce_i) begin
      if (take_pwr) begin
        pend_reg <= 3'h0;
      end
      if (sleep_req_i) begin
        pend_reg <= 3'(sacp_pkg::SLEEP_PULSES);
      end else if (nap_req_i) begin
        pend_reg <= 3'(sacp_pkg::NAP_PULSES);
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= sacp_pkg::H_IDLE;
      tmr_reg   <= 8'h00;
      per_reg   <= 8'hff;
      edge_reg  <= 4'h0;
      pls_reg   <= 3'h0;
      rx_reg    <= 13'h0000;
      push_reg  <= 1'b0;
      sck_reg   <= 1'b0;
      convert_strobe_reg  <= 1'b0;
    end else if (ce_i) begin
      push_reg <= 1'b0;
      tmr_reg  <= tmr_reg + 8'h01;
      if (per_reg != 8'hff) begin
        per_reg <= per_reg + 8'h01;
      end
      case (state_reg)
        sacp_pkg::H_IDLE: begin
          tmr_reg <= 8'h00;
          if (take_pwr) begin
            // Strobes with serial clock held low
            pls_reg   <= pend_reg;
            convert_strobe_reg  <= 1'b1;
            state_reg <= sacp_pkg::H_PLS_H;
          end else if (run_i && fifo_ready && per_reg >= THRU) begin
            convert_strobe_reg  <= 1'b1;
            per_reg   <= 8'h00;
            state_reg <= sacp_pkg::H_STRB;
          end
        end
        sacp_pkg::H_STRB: begin
          // Strobe leads the first edge by half a period
          if (tmr_reg == HALF_M1) begin
            tmr_reg   <= 8'h00;
            sck_reg   <= 1'b1;
            edge_reg  <= 4'h1;
            state_reg <= sacp_pkg::H_SCKH;
          end
        end
        sacp_pkg::H_SCKH: begin
          if (tmr_reg == HALF_M1) begin
            tmr_reg   <= 8'h00;
            sck_reg   <= 1'b0;
            convert_strobe_reg  <= 1'b0;
            state_reg <= sacp_pkg::H_SCKL;
          end
        end
        sacp_pkg::H_SCKL: begin
          if (tmr_reg == HALF_M1) begin
            tmr_reg <= 8'h00;
            if (edge_reg == 4'(sacp_pkg::CONVERT_STROBE_EDGES)) begin
              state_reg <= sacp_pkg::H_WAIT;
            end else begin
              // Capture on the rising edge we make
              sck_reg   <= 1'b1;
              edge_reg  <= edge_reg + 4'h1;
              rx_reg    <= {rx_reg[11:0], sdo_sync_reg[1]};
              push_reg  <= (edge_reg == 4'(sacp_pkg::CONVERT_STROBE_EDGES - 1));
              state_reg <= sacp_pkg::H_SCKH;
            end
          end
        end
        sacp_pkg::H_WAIT: begin
          if (tmr_reg == WAIT_M1) begin
            state_reg <= sacp_pkg::H_IDLE;
          end
        end
        sacp_pkg::H_PLS_H: begin
          if (tmr_reg == HALF_M1) begin
            tmr_reg   <= 8'h00;
            convert_strobe_reg  <= 1'b0;
            state_reg <= sacp_pkg::H_PLS_L;
          end
        end
        sacp_pkg::H_PLS_L: begin
          if (tmr_reg == HALF_M1) begin
            tmr_reg <= 8'h00;
            pls_reg <= pls_reg - 3'h1;
            if (pls_reg == 3'h1) begin
              state_reg <= sacp_pkg::H_IDLE;
            end else begin
              convert_strobe_reg  <= 1'b1;
              state_reg <= sacp_pkg::H_PLS_H;
            end
          end
        end
        default: begin
          state_reg <= sacp_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Received words; a full FIFO stops new conversion strobes
  sacp_fifo #(
    .WIDTH (sacp_pkg::WORD_BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_data_i   (rx_reg),
    .in_valid_i  (push_reg),
    .in_ready_o  (fifo_ready),
    .out_data_o  (word_o),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i)
  );
endmodule : sacp_host

// ### hw/sacp_pkg.sv
package sacp_pkg;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int RES_BITS   = 12;            // Result bits per word
  localparam int WORD_BITS  = 13;            // Ready bit plus result
  localparam int CONVERT_STROBE_EDGES = 14;            // Serial edges per conversion
  localparam logic [11:0] BIP_FLIP = 12'h800; // Offset flip for bipolar codes
  localparam logic READY_RST = 1'b1;         // Ready bit after reset

  // ****************************************
  // Link timing
  // ****************************************
  localparam int CLK_NS      = 10;           // System clock period
  localparam int THRU_NS     = 455;          // Least sampling period
  localparam int THRU_CYC    = (THRU_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_MIN_NS  = 28;           // Shortest serial period
  localparam int SCK_MAX_NS  = 10000;        // Longest serial period
  localparam int ACQ_NS      = 57;           // Last edge to next strobe
  localparam int ACQ_CYC     = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_NS      = 48;           // Gap between conversions
  localparam int GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_PS    = 7300;         // Strobe to edge setup, 7.3 ns
  localparam int SETUP_CYC   = (SETUP_PS + CLK_NS * 1000 - 1) / (CLK_NS * 1000);
  localparam int SCK_HALF_DEF = 4;           // Host half period in cycles

  // ****************************************
  // Power and reference
  // ****************************************
  localparam int NAP_PULSES   = 2;           // Strobes for light power-down
  localparam int SLEEP_PULSES = 4;           // Strobes for deep sleep
  localparam int SETTLE_MS    = 2;           // Reference settling
  localparam int READY_MS     = 10;          // Ready delay after settling
  localparam int CYC_PER_MS   = 1000000 / CLK_NS;
  localparam int SETTLE_CYC   = SETTLE_MS * CYC_PER_MS;
  localparam int READY_CYC    = READY_MS * CYC_PER_MS;

  // Power states of the converter
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_NAP    = 2'b01,
    PWR_SLEEP  = 2'b10
  } sacp_pwr_t;

  // Converter phase
  typedef enum logic {
    PH_ACQ  = 1'b0,
    PH_BUSY = 1'b1
  } sacp_phase_t;

  // Host sequencer states
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_STRB  = 3'b001,
    H_SCKH  = 3'b010,
    H_SCKL  = 3'b011,
    H_WAIT  = 3'b100,
    H_PLS_H = 3'b101,
    H_PLS_L = 3'b110
  } sacp_host_st_t;

  // Sample to output code; bipolar input is two's complement
  function automatic logic [11:0] to_code(input logic [11:0] s, input logic bip);
    return bip ? (s ^ BIP_FLIP) : s;
  endfunction : to_code

endpackage : sacp_pkg

// ### hw/sacp_link_if.sv
`timescale 1ns/100ps
// ****************************************
// Three-wire converter link
// ****************************************
interface sacp_link_if;
  logic sck;            // Serial clock from host
  logic convert_strobe; // Convert strobe from host
  logic sdo;            // Serial data driven by device
  logic sdo_oe;         // Device drives data line
  logic sdo_line;       // Resolved data line

  // Undriven line reads low
  assign sdo_line = sdo_oe & sdo;

  modport dev (input sck, input convert_strobe, output sdo, output sdo_oe);
  modport host (output sck, output convert_strobe, input sdo_line);
endinterface : sacp_link_if

// ### hw/sacp_fifo.sv
`timescale 1ns/100ps
// ****************************************
// Word FIFO
// ****************************************
module sacp_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage
  logic [AW:0]      wr_ptr_reg;    // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_reg;    // Read pointer with wrap bit
  logic             push;
  logic             pop;

  // Full when pointers differ only in wrap bit
  assign in_ready_o  = ~((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                         (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
  assign push        = ce_i & in_valid_i & in_ready_o;
  assign pop         = ce_i & out_valid_o & out_ready_i;

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // Pointer update
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
      end
    end
  end
endmodule : sacp_fifo

// ### hw/sacp_dev.sv
`timescale 1ns/100ps
// Summary of operation
// - Fourteen edges convert, then acquire until strobe
// - Host keeps sampling period at least 455 ns
// - Host serial period between 28 and 10000 ns
// - Host waits 57 ns after fourteenth edge
// - Host leaves 48 ns between conversions
// - Short strobe setup delays data one clock
// - Host raises strobe half clock before edge
// - Host captures each bit on rising edge
// - Word holds twelve result bits plus ready
// - Bipolar code flips at minus half LSB
// - Deep sleep entry clears the ready bit
// - Ready returns 10 ms after reference settles
// - Serial edges wake; reference settles in 2 ms
// - Strobe rise holds input, starts conversion
// - Rising edges advance the count; thirteen of them shift data
// - Two idle-clock strobes nap, four sleep
// - Word carries the previous conversion sample

// ****************************************
// Device end: sequencing and serial output
// ****************************************
module sacp_dev #(
  parameter int SETTLE_CYC = sacp_pkg::SETTLE_CYC,
  parameter int READY_CYC  = sacp_pkg::READY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  sacp_link_if.dev         link,
  input  wire logic [11:0] sample_i,
  input  wire logic        bipolar_i,
  output logic             converting_o,
  output logic             acquiring_o,
  output logic             nap_o,
  output logic             sleep_o,
  output logic             ref_settled_o,
  output logic             ready_bit_o
);
  localparam int TOT_CYC = SETTLE_CYC + READY_CYC;
  localparam int TW      = $clog2(TOT_CYC + 1);
  localparam logic [3:0] EDGES  = 4'(sacp_pkg::CONVERT_STROBE_EDGES);
  localparam logic [3:0] BITS   = 4'(sacp_pkg::WORD_BITS);
  localparam logic [3:0] SETUP  = 4'(sacp_pkg::SETUP_CYC);
  localparam logic [2:0] NAP_N  = 3'(sacp_pkg::NAP_PULSES);
  localparam logic [2:0] SLP_N  = 3'(sacp_pkg::SLEEP_PULSES);

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0]  sck_sync_reg;             // Serial clock synchroniser
  logic [1:0]  convert_strobe_sync_reg;            // Strobe synchroniser
  logic        sck_q_reg;                // Previous synced clock
  logic        convert_strobe_q_reg;               // Previous synced strobe
  logic        sck_rise;
  logic        convert_strobe_rise;
  sacp_pkg::sacp_phase_t phase_reg;      // Converting or acquiring
  logic [11:0] result_reg;               // Code of held sample
  logic [12:0] shift_reg;                // Outgoing word
  logic [3:0]  edge_reg;                 // Edges since strobe
  logic [3:0]  edge_next;
  logic [3:0]  since_reg;                // Cycles since strobe
  logic        late_reg;                 // Output runs one edge late
  logic        late_now;
  logic [3:0]  slot;                     // Output bit slot
  logic        sdo_reg;
  logic        sdo_oe_reg;
  sacp_pkg::sacp_pwr_t pwr_reg;          // Power state
  logic [2:0]  pls_reg;                  // Strobes with clock idle
  logic [2:0]  pls_next;
  logic        ref_run_reg;              // Reference wake timer on
  logic [TW-1:0] ref_cnt_reg;            // Reference wake timer
  logic        settled_reg;
  logic        ready_reg;                // Reference-ready status

  assign link.sdo      = sdo_reg;
  assign link.sdo_oe   = sdo_oe_reg;
  assign converting_o  = (phase_reg == sacp_pkg::PH_BUSY);
  assign acquiring_o   = (phase_reg == sacp_pkg::PH_ACQ);
  assign nap_o         = (pwr_reg == sacp_pkg::PWR_NAP);
  assign sleep_o       = (pwr_reg == sacp_pkg::PWR_SLEEP);
  assign ref_settled_o = settled_reg;
  assign ready_bit_o   = ready_reg;

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_sync_reg  <= 2'b00;
      convert_strobe_sync_reg <= 2'b00;
      sck_q_reg     <= 1'b0;
      convert_strobe_q_reg    <= 1'b0;
    end else if (ce_i) begin
      sck_sync_reg  <= {sck_sync_reg[0], link.sck};
      convert_strobe_sync_reg <= {convert_strobe_sync_reg[0], link.convert_strobe};
      sck_q_reg     <= sck_sync_reg[1];
      convert_strobe_q_reg    <= convert_strobe_sync_reg[1];
    end
  end

  assign sck_rise  = ce_i & sck_sync_reg[1] & ~sck_q_reg;
  assign convert_strobe_rise = ce_i & convert_strobe_sync_reg[1] & ~convert_strobe_q_reg;

  // ****************************************
  // Output slot arithmetic
  // ****************************************
  always_comb begin
    edge_next = (edge_reg == 4'hf) ? edge_reg : edge_reg + 4'h1;
    // First edge decides lateness from strobe setup
    late_now  = (edge_reg == 4'h0) ? (since_reg < SETUP) : late_reg;
    slot      = edge_next - {3'b000, late_now};
  end

  // ****************************************
  // Conversion and serial shifter
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg  <= sacp_pkg::PH_ACQ;
      result_reg <= 12'h000;
      shift_reg  <= 13'h0000;
      edge_reg   <= 4'hf;
      since_reg  <= 4'hf;
      late_reg   <= 1'b0;
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else if (convert_strobe_rise) begin
      // Hold input; send previous result with ready first
      result_reg <= sacp_pkg::to_code(sample_i, bipolar_i);
      shift_reg  <= {ready_reg, result_reg};
      phase_reg  <= sacp_pkg::PH_BUSY;
      since_reg  <= 4'h1;
      // Coincident edge counts but carries no bit
      edge_reg   <= sck_rise ? 4'h1 : 4'h0;
      late_reg   <= sck_rise;
      sdo_oe_reg <= 1'b0;
    end else if (ce_i) begin
      if (since_reg != 4'hf) begin
        since_reg <= since_reg + 4'h1;
      end
      if (sck_rise && edge_reg != 4'hf) begin
        edge_reg <= edge_next;
        late_reg <= late_now;
        if (edge_next == EDGES) begin
          phase_reg <= sacp_pkg::PH_ACQ;
        end
        if (slot != 4'h0 && slot <= BITS) begin
          // Next bit driven after this edge, MSB first
          sdo_reg    <= shift_reg[12];
          shift_reg  <= {shift_reg[11:0], 1'b0};
          sdo_oe_reg <= 1'b1;
        end else begin
          sdo_oe_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Power states and reference ready
  // ****************************************
  assign pls_next = (pls_reg == 3'h7) ? pls_reg : pls_reg + 3'h1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_reg     <= sacp_pkg::PWR_ACTIVE;
      pls_reg     <= 3'h0;
      ref_run_reg <= 1'b0;
      ref_cnt_reg <= '0;
      settled_reg <= 1'b1;
      ready_reg   <= sacp_pkg::READY_RST;
    end else if (ce_i) begin
      // Wake timer: settle, then ready delay
      if (ref_run_reg) begin
        ref_cnt_reg <= ref_cnt_reg + TW'(1);
      end
      if (sck_rise) begin
        // Any serial edge wakes and clears the strobe count
        pls_reg <= 3'h0;
        pwr_reg <= sacp_pkg::PWR_ACTIVE;
        if (pwr_reg == sacp_pkg::PWR_SLEEP) begin
          ref_run_reg <= 1'b1;
          ref_cnt_reg <= '0;
        end
      end else if (convert_strobe_rise) begin
        pls_reg <= pls_next;
        if (pls_next == SLP_N) begin
          pwr_reg     <= sacp_pkg::PWR_SLEEP;
          ref_run_reg <= 1'b0;
          settled_reg <= 1'b0;
          ready_reg   <= 1'b0;
        end else if (pls_next == NAP_N) begin
          pwr_reg <= sacp_pkg::PWR_NAP;
        end
      end
      // Settled and ready sets win over a same-cycle clear
      if (ref_run_reg && ref_cnt_reg == TW'(SETTLE_CYC - 1)) begin
        settled_reg <= 1'b1;
      end
      if (ref_run_reg && ref_cnt_reg == TW'(TOT_CYC - 1)) begin
        ready_reg   <= 1'b1;
        ref_run_reg <= 1'b0;
      end
    end
  end
endmodule : sacp_dev

// ### sim/sacp_link_sva.sv
`timescale 1ns/100ps
// ****************************************
// Link checker
// ****************************************
module sacp_link_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sck,
  input wire logic convert_strobe,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic [5:0] sck_sh;    // Recent serial clock samples
  logic [7:0] oe_cnt;    // Cycles the data line is driven
  logic [7:0] per_cnt;   // Cycles since last strobe rise
  logic       strb_d;    // Strobe one cycle ago
  logic       strb_seen; // Strobe since last release
  logic       sck_seen;  // Serial edge since last strobe
  wire  logic sck_up = |(sck_sh[4:1] & ~sck_sh[5:2]);

  // Serial clock history
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) sck_sh <= 6'h00;
    else sck_sh <= {sck_sh[4:0], sck};
  end

  // Length of each driven stretch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) oe_cnt <= 8'h00;
    else oe_cnt <= sdo_oe ? oe_cnt + 8'h01 : 8'h00;
  end

  // Strobe spacing and link events
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strb_d    <= 1'b0;
      per_cnt   <= 8'hff;
      strb_seen <= 1'b0;
      sck_seen  <= 1'b0;
    end else begin
      strb_d <= convert_strobe;
      if (convert_strobe && !strb_d) per_cnt <= 8'h00;
      else if (per_cnt != 8'hff) per_cnt <= per_cnt + 8'h01;
      if (convert_strobe && !strb_d) strb_seen <= 1'b1;
      else if (!sdo_oe && oe_cnt != 8'h00) strb_seen <= 1'b0;
      if (convert_strobe && !strb_d) sck_seen <= 1'b0;
      else if (sck && !sck_sh[0]) sck_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence convert_strobe_start; $rose(convert_strobe); endsequence
  sequence word_end; $fell(sdo_oe); endsequence

  sck_width_a: assert property ($rose(sck) |-> sck[*4])
    else $error("serial clock high phase too short");
  strobe_setup_a: assert property (convert_strobe_start |-> !sck[*4])
    else $error("serial edge too soon after strobe");
  data_edge_a: assert property (($changed(sdo) || $changed(sdo_oe)) |-> sck_up)
    else $error("data line moved without serial edge");
  bit_hold_a: assert property ($changed(sdo) |=> $stable(sdo)[*3])
    else $error("data bit not held");
  word_len_a: assert property (word_end |-> oe_cnt >= 8'd103 && oe_cnt <= 8'd105)
    else $error("word length wrong");
  acq_gap_a: assert property (word_end |-> !convert_strobe[*3])
    else $error("strobe too soon after last edge");
  release_a: assert property ($rose(sdo_oe) |-> strb_seen)
    else $error("data driven without new strobe");
  rate_a: assert property (convert_strobe_start and sck_seen |-> per_cnt >= 8'd45)
    else $error("sampling period too short");
endmodule : sacp_link_sva

// ### sim/serial_adc_conversion_port_bench.sv
`timescale 1ns/100ps
module serial_adc_conversion_port_bench;
  logic clk_i, rst_n_i, run_i, nap_req_i, sleep_req_i, word_ready_i, bipolar_i, drain;
  logic [11:0] sample_i, held, pend;
  logic [12:0] word_o;
  logic        word_valid_o, busy_o, nap_o, sleep_o, setl_o, rdy_o, cnv_o, acq_o, ce_i;
  logic [15:0] lfsr;
  logic        strb_q, sck_q, armed, rdy_exp;
  logic [12:0] exp_q[$];
  int          fail_count, n_compared, cyc, chg;
  sacp_link_if link();
  sacp_dev #(.SETTLE_CYC(20), .READY_CYC(50)) i_sacp_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_i(ce_i), .link(link), .sample_i(sample_i), .bipolar_i(bipolar_i), .converting_o(cnv_o),
    .acquiring_o(acq_o), .nap_o(nap_o), .sleep_o(sleep_o), .ref_settled_o(setl_o),
    .ready_bit_o(rdy_o));
  sacp_host i_sacp_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .link(link),
    .run_i(run_i), .nap_req_i(nap_req_i), .sleep_req_i(sleep_req_i), .word_o(word_o),
    .word_valid_o(word_valid_o), .word_ready_i(word_ready_i), .busy_o(busy_o));
  sacp_link_sva i_sacp_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck(link.sck),
    .convert_strobe(link.convert_strobe), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic cmp_word(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic clks(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : clks
  task automatic idle_wait;
    clks(4);
    for (int i = 0; i < 400 && busy_o !== 1'b0; i++) clks(1);
  endtask : idle_wait
  task automatic empty_wait;
    for (int i = 0; i < 9000 && exp_q.size() != 0; i++) clks(1);
  endtask : empty_wait
  task automatic pulse(input logic sl);
    if (sl) sleep_req_i = 1'b1;
    else nap_req_i = 1'b1;
    clks(1);
    sleep_req_i = 1'b0;
    nap_req_i   = 1'b0;
  endtask : pulse

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Expected words, sample stimulus, stall pattern, timeout
  always @(posedge clk_i) begin
    strb_q <= link.convert_strobe;
    sck_q  <= link.sck;
    lfsr   <= lfsr_next(lfsr);
    word_ready_i <= #1 drain & lfsr[0];
    cyc <= cyc + 1;
    chg <= chg + 1;
    if (cyc > 30000) begin
      fail_count++;
      stop_test();
    end
    if (link.convert_strobe && !strb_q) begin
      pend  <= held;
      held  <= bipolar_i ? sample_i ^ sacp_pkg::BIP_FLIP : sample_i;
      armed <= 1'b1;
      chg   <= 0;
    end
    if (link.sck && !sck_q && armed) begin
      exp_q.push_back({rdy_exp, pend});
      armed   <= 1'b0;
      rdy_exp <= 1'b1;
    end
    if (chg == 6) sample_i <= #1 (lfsr[3:0] == 4'h0) ? {12{lfsr[4]}} : lfsr[15:4];
  end

  // Word monitor
  always @(posedge clk_i) begin
    // A frozen FIFO pops nothing
    if (word_valid_o === 1'b1 && word_ready_i === 1'b1 && ce_i === 1'b1)
      cmp_word(word_o, exp_q.size() != 0 ? exp_q.pop_front() : 13'hx);
  end

  initial begin
    {rst_n_i, run_i, nap_req_i, sleep_req_i, drain, bipolar_i, word_ready_i} = 7'h00;
    ce_i = 1'b1;
    {strb_q, sck_q, armed, held, pend} = 27'h0;
    sample_i = 12'h5a5;
    lfsr = 16'd65171;
    rdy_exp = 1'b1;
    {fail_count, n_compared, cyc, chg} = '0;
    clks(12);
    rst_n_i = 1'b1;
    run_i = 1'b1;
    for (int i = 0; i < 6000 && exp_q.size() < 32; i++) clks(1);
    clks(300);
    cmp_bit(exp_q.size() == 32, 1'b1);
    cmp_bit(busy_o, 1'b0);
    cmp_bit(acq_o, 1'b1);
    cmp_bit(cnv_o, 1'b0);
    drain = 1'b1;
    clks(2000);
    run_i = 1'b0;
    idle_wait();
    empty_wait();
    bipolar_i = 1'b1;
    rdy_exp = 1'b0;
    pulse(1'b1);
    idle_wait();
    clks(5);
    cmp_bit(sleep_o, 1'b1);
    cmp_bit(rdy_o, 1'b0);
    run_i = 1'b1;
    for (int i = 0; i < 200 && link.sck !== 1'b1; i++) clks(1);
    clks(6);
    cmp_bit(sleep_o, 1'b0);
    cmp_bit(cnv_o, 1'b1);
    cmp_bit(setl_o, 1'b0);
    clks(80);
    cmp_bit(setl_o, 1'b1);
    cmp_bit(rdy_o, 1'b1);
    clks(1500);
    run_i = 1'b0;
    idle_wait();
    // Frozen ends ignore a sleep request
    ce_i = 1'b0;
    pulse(1'b1);
    clks(10);
    ce_i = 1'b1;
    clks(60);
    cmp_bit(sleep_o, 1'b0);
    cmp_bit(busy_o, 1'b0);
    pulse(1'b0);
    idle_wait();
    clks(5);
    cmp_bit(nap_o, 1'b1);
    cmp_bit(sleep_o, 1'b0);
    run_i = 1'b1;
    clks(100);
    cmp_bit(nap_o, 1'b0);
    clks(1000);
    run_i = 1'b0;
    idle_wait();
    empty_wait();
    cmp_bit(exp_q.size() == 0, 1'b1);
    stop_test();
  end
endmodule : serial_adc_conversion_port_bench
